/* cycle_time_counter.sv */
// Offset, cycle-count and seconds counter of the cycle timer
module cycle_time_counter (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Advance controls
    input wire logic enable,
    input wire logic offsetTick,
    input wire logic externalCycle,
    // Loads
    input wire logic hostWrite,
    input wire logic [31:0] hostData,
    input wire logic packetLoad,
    input wire logic [31:0] packetData,
    // State
    output logic [31:0] cycleTime,
    output logic cycleBump
);
    logic [11:0] offset;
    logic [12:0] count;
    logic [6:0] seconds;
    logic [11:0] next_offset;
    logic [12:0] next_count;
    logic [6:0] next_seconds;
    wire offsetWrap = offset == cycle_timer_pkg::OFFSET_LAST;
    wire countWrap = count == cycle_timer_pkg::COUNT_LAST;
    wire bumpCount = enable && (externalCycle || (offsetTick && offsetWrap)); // R4 R8 R10

    assign cycleTime = {seconds, count, offset};

    always_comb begin
        next_offset = offset;
        next_count = count;
        next_seconds = seconds;
        if (hostWrite) begin
            {next_seconds, next_count, next_offset} = hostData; // R3
        end else if (packetLoad) begin
            {next_seconds, next_count, next_offset} = packetData; // R9
        end else if (enable) begin // R10
            if (externalCycle) begin
                next_offset = '0; // R4
            end else if (offsetTick) begin
                next_offset = offsetWrap ? '0 : offset + 12'h001; // R1 R7
            end
            if (bumpCount) begin
                next_count = countWrap ? '0 : count + 13'h0001; // R2 R20
                if (countWrap) begin
                    next_seconds = seconds + 7'h01; // R20
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            {seconds, count, offset} <= cycle_timer_pkg::TIME_RESET; // R18 R21
            cycleBump <= 1'b0;
        end else begin
            offset <= next_offset;
            count <= next_count;
            seconds <= next_seconds;
            cycleBump <= bumpCount && !hostWrite && !packetLoad;
        end
    end
endmodule

/* cycle_timer_chk.sv */
// Port assertions of the cycle timer and monitor
module cycle_timer_chk (
    input wire logic clock, srst, cycleMaster, cycleTimerEnable, regSelect, regWrite,
    input wire logic cycle_tick_out, cycleStartRequest, regReadValid, rxQuadletValid,
    input wire logic rxIsCycleStart, queueWrite, queueCycleMark, cycle_started_flag,
    input wire logic cycleLostFlag,
    input wire logic [7:0] register_addr_bus,
    input wire logic [31:0] regWriteData, regReadData, rxQuadlet, isochronousCycleTime
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    wire logic rd14 = regSelect && !regWrite && register_addr_bus == 8'h14;
    wire logic wr14 = regSelect && regWrite && register_addr_bus == 8'h14;
    wire logic rxs = rxQuadletValid && rxIsCycleStart;
    wire logic [31:0] tm = isochronousCycleTime;
    property p_rd; rd14 |=> regReadValid && regReadData == tm; endproperty
    a_rd: assert property (p_rd) else $error("read data");
    property p_wr; wr14 |=> ##1 tm == $past(regWriteData, 2); endproperty
    a_wr: assert property (p_wr) else $error("write lost");
    property p_hold; !(cycleTimerEnable || regSelect || rxQuadletValid) |=> ##1 $stable(tm); endproperty
    a_hold: assert property (p_hold) else $error("timer moved");
    property p_load;
        rxs && !cycleMaster && !wr14 |=> cycle_started_flag ##1 tm == $past(rxQuadlet, 2);
    endproperty
    a_load: assert property (p_load) else $error("start load");
    property p_noQueue; rxs |=> !queueWrite || queueCycleMark; endproperty
    a_noQueue: assert property (p_noQueue) else $error("start queued");
    property p_req; cycle_tick_out && cycleMaster |-> ##[0:1] cycleStartRequest; endproperty
    a_req: assert property (p_req) else $error("no start request");
    property p_range; tm[11:0] <= 12'hbff && tm[24:12] <= 13'h1f3f; endproperty
    a_range: assert property (p_range) else $error("field range");
    property p_reset; disable iff (1'b0) srst |=> !(cycle_started_flag || cycleLostFlag); endproperty
    a_reset: assert property (p_reset) else $error("flags after reset");
endmodule
bind serial_bus_cycle_timer_monitor cycle_timer_chk i_chk (.*);

/* cycle_timer_pkg.sv */
// Constants for the serial-bus cycle timer and cycle monitor
// Contract
// R1: Low 12 timer bits count modulo 3072 at the 24.576 MHz rate; only with the internal source, external source only clears them.
// R2: Next 13 bits count 125 us cycles; top 7 bits count seconds.
// R3: Host reads and writes the 32-bit timer at 14h; also seen at 200h.
// R4: External source: each rising cycle input edge bumps cycle count, clears offset.
// R5: External source: every cycle count increment pulses the cycle output.
// R6: System selects the external source only on the cycle master.
// R7: Internal source: offset advances from the 24.576 MHz clock.
// R8: Internal source: each offset rollover bumps cycle count and pulses output.
// R9: Non-master loads the timer from each received cycle-start packet; a host write at 14h in the same cycle wins and the packet is not loaded.
// R10: Timer holds still while the timer enable bit is clear; host writes at 14h and cycle-start packet loads still change it.
// R11: Cycle pulse starts a cycle: master sends cycle start, others expect one.
// R12: Cycle master sends cycle-start packets on its own, no host involvement.
// R13: Cycle-started flag sets when cycle start is sent or received.
// R14: Missing expected cycle-start packet sets the cycle-lost flag.
// R15: Received cycle-start goes to the timer, never into the receive queue.
// R16: With mark insert enabled, a cycle-mark entry is queued at cycle end.
// R17: Internal 24.576 MHz tick derives from the 49.152 MHz phy clock.
// R18: Reset clears the cycle timer and cycle monitor state.
// R19: System holds the external cycle input high when unused.
// R20: Cycle count wraps 7999 to zero bumping seconds; seconds wrap at 127.
// R21: Reset clears all timer fields and both flags.
package cycle_timer_pkg;
    localparam int OFFSET_WIDTH = 12;
    localparam int COUNT_WIDTH = 13;
    localparam int SECONDS_WIDTH = 7;
    localparam int TIME_WIDTH = 32;
    localparam int OFFSET_LSB = 0;
    localparam int COUNT_LSB = 12;
    localparam int SECONDS_LSB = 25;
    localparam logic [11:0] OFFSET_LAST = 12'hbff;
    localparam logic [12:0] COUNT_LAST = 13'h1f3f;
    localparam logic [6:0] SECONDS_LAST = 7'h7f;
    localparam logic [7:0] ADDR_CYCLE_TIME = 8'h14;
    localparam logic [11:0] BUS_SPACE_CYCLE_TIME = 12'h200;
    localparam logic [31:0] TIME_RESET = 32'h0000_0000;
endpackage

/* phy_link_model.sv */
// Phy clock and cycle-start transmitter model
module phy_link_model (
    input wire logic clock,
    input wire logic cycleStartRequest,
    output logic phy_system_clock = 1'h0,
    output logic cycleStartSent = 1'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pend = 1'h0;
    always #10.1725 phy_system_clock = !phy_system_clock;
    always @(posedge clock) begin
        pend <= cycleStartRequest;
        cycleStartSent <= pend;
    end
endmodule

/* serial_bus_cycle_timer_monitor.sv */
// Cycle timer and cycle monitor of the serial-bus link controller
module serial_bus_cycle_timer_monitor (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Pins
    input wire logic phy_system_clock,
    input wire logic ext_cycle_tick_in,
    output logic cycle_tick_out,
    // Control bits
    input wire logic cycle_source_select,
    input wire logic cycleTimerEnable,
    input wire logic cycleMaster,
    input wire logic cycle_mark_insert_enable,
    // Host register port
    input wire logic regSelect,
    input wire logic regWrite,
    input wire logic [7:0] register_addr_bus,
    input wire logic [31:0] regWriteData,
    output logic [31:0] regReadData,
    output logic regReadValid,
    // Serial-bus register space read
    input wire logic busSpaceRead,
    input wire logic [11:0] busSpaceAddr,
    output logic [31:0] busSpaceData,
    output logic busSpaceValid,
    // Receiver path
    input wire logic rxQuadletValid,
    input wire logic [31:0] rxQuadlet,
    input wire logic rxIsCycleStart,
    output logic queueWrite,
    output logic [31:0] queueData,
    output logic queueCycleMark,
    // Transmitter path
    output logic cycleStartRequest,
    input wire logic cycleStartSent,
    // Flags and registered timer copy
    input wire logic clearCycleStarted,
    input wire logic clearCycleLost,
    output logic cycle_started_flag,
    output logic cycleLostFlag,
    output logic [31:0] isochronousCycleTime
);
    logic [1:0] pinMeta;
    logic [1:0] pinSync;
    logic phyLast;
    logic extLast;
    logic halfToggle;
    logic awaitingStart;
    logic [31:0] cycleTime;
    logic cycleBump;

    // Pin synchronisers, phy clock in bit 0, cycle input in bit 1
    wire logic [1:0] pinRaw = {ext_cycle_tick_in, phy_system_clock};

    always_ff @(posedge clock) begin
        pinMeta <= pinRaw;
        pinSync <= pinMeta;
    end

    wire logic phySync = pinSync[0];
    wire logic extSync = pinSync[1];

    wire phyRise = phySync && !phyLast;
    wire offsetTick = phyRise && halfToggle && !cycle_source_select; // R7 R17
    wire externalCycle = extSync && !extLast && cycle_source_select; // R4 R6 R19
    wire hostHit = register_addr_bus == cycle_timer_pkg::ADDR_CYCLE_TIME;
    wire hostWrite = regSelect && regWrite && hostHit; // R3
    wire hostRead = regSelect && !regWrite;
    wire rxStart = rxQuadletValid && rxIsCycleStart;
    wire packetLoad = rxStart && !cycleMaster; // R9 R15
    wire startSeen = cycleMaster ? cycleStartSent : rxStart; // R13
    wire startLost = !cycleMaster && awaitingStart && cycleBump && !rxStart; // R14
    wire logic next_halfToggle = phyRise ? !halfToggle : halfToggle; // R17
    wire logic next_startedFlag = startSeen || (cycle_started_flag && !clearCycleStarted); // R13
    wire logic next_lostFlag = startLost || (cycleLostFlag && !clearCycleLost); // R14

    // Read and queue selections
    wire logic rxPlain = rxQuadletValid && !rxIsCycleStart; // R15
    wire logic markEntry = cycleBump && cycle_mark_insert_enable; // R16
    wire logic busSpaceHit = busSpaceAddr == cycle_timer_pkg::BUS_SPACE_CYCLE_TIME;
    wire logic [31:0] next_regReadData = (hostRead && hostHit) ? cycleTime : '0; // R3
    wire logic [31:0] next_busSpaceData = (busSpaceRead && busSpaceHit) ? cycleTime : '0; // R3
    wire logic [31:0] next_queueData = rxPlain ? rxQuadlet : cycleTime;

    cycle_time_counter timer (
        .clock(clock),
        .srst(srst),
        .enable(cycleTimerEnable),
        .offsetTick(offsetTick),
        .externalCycle(externalCycle),
        .hostWrite(hostWrite),
        .hostData(regWriteData),
        .packetLoad(packetLoad),
        .packetData(rxQuadlet),
        .cycleTime(cycleTime),
        .cycleBump(cycleBump)
    );

    // Edge history of the synchronised pins
    always_ff @(posedge clock) begin
        if (srst) begin
            phyLast <= 1'b0;
            extLast <= 1'b1;
        end else begin
            phyLast <= phySync;
            extLast <= extSync;
        end
    end

    // Half-rate divider of the phy clock
    always_ff @(posedge clock) begin
        if (srst) begin
            halfToggle <= 1'b0;
        end else begin
            halfToggle <= next_halfToggle; // R17
        end
    end

    // Cycle pulse and start request
    always_ff @(posedge clock) begin
        if (srst) begin
            cycle_tick_out <= 1'b0;
            cycleStartRequest <= 1'b0;
        end else begin
            cycle_tick_out <= cycleBump; // R5 R8 R11
            cycleStartRequest <= cycleBump && cycleMaster; // R11 R12
        end
    end

    // Expected cycle-start tracking
    always_ff @(posedge clock) begin
        if (srst) begin
            awaitingStart <= 1'b0;
        end else if (cycleBump && !cycleMaster) begin
            awaitingStart <= 1'b1; // R11
        end else if (rxStart || cycleMaster) begin
            awaitingStart <= 1'b0;
        end
    end

    // Sticky flags, a set beats a clear
    always_ff @(posedge clock) begin
        if (srst) begin
            cycle_started_flag <= 1'b0;
            cycleLostFlag <= 1'b0;
        end else begin
            cycle_started_flag <= next_startedFlag; // R13
            cycleLostFlag <= next_lostFlag; // R14
        end
    end

    // Receive queue path
    always_ff @(posedge clock) begin
        if (srst) begin
            queueWrite <= 1'b0;
            queueCycleMark <= 1'b0;
            queueData <= '0;
        end else begin
            queueCycleMark <= markEntry; // R16
            queueWrite <= rxPlain || markEntry; // R15 R16
            queueData <= next_queueData;
        end
    end

    // Host register reads
    always_ff @(posedge clock) begin
        if (srst) begin
            regReadData <= '0;
            regReadValid <= 1'b0;
        end else begin
            regReadData <= next_regReadData; // R3
            regReadValid <= hostRead;
        end
    end

    // Serial-bus register space reads
    always_ff @(posedge clock) begin
        if (srst) begin
            busSpaceData <= '0;
            busSpaceValid <= 1'b0;
        end else begin
            busSpaceData <= next_busSpaceData; // R3
            busSpaceValid <= busSpaceRead;
        end
    end

    // Registered copy of the timer
    always_ff @(posedge clock) begin
        if (srst) begin
            isochronousCycleTime <= cycle_timer_pkg::TIME_RESET; // R21
        end else begin
            isochronousCycleTime <= cycleTime;
        end
    end
endmodule

/* serial_bus_cycle_timer_monitor_test.sv */
// Self-checking bench of the cycle timer and monitor
module serial_bus_cycle_timer_monitor_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex;} row_type;
    row_type rows [3] = '{'{8'h20, 32'hfff, 8'h14, 32'h0}, '{8'h14, 32'habc_d5a5, 8'h14,
        32'habc_d5a5}, '{8'h14, 32'h123, 8'h18, 32'h0}};
    logic clock = '0, srst = '1, ext_cycle_tick_in = '1, cycle_source_select = '0;
    logic cycleTimerEnable = '0, cycleMaster = '0, cycle_mark_insert_enable = '1;
    logic regSelect = '0, regWrite = '0, busSpaceRead = '0, rxQuadletValid = '0;
    logic rxIsCycleStart = '0, clearCycleStarted = '0, clearCycleLost = '0;
    logic [7:0] register_addr_bus = '0;
    logic [11:0] busSpaceAddr = '0;
    logic [31:0] regWriteData = '0, rxQuadlet = '0, regReadData, busSpaceData, queueData;
    logic [31:0] isochronousCycleTime, readWord;
    logic phy_system_clock, cycle_tick_out, regReadValid, busSpaceValid, queueWrite;
    logic queueCycleMark, cycleStartRequest, cycleStartSent, cycle_started_flag, cycleLostFlag;
    int err_count = 0, tests_run = 0, cycles = 0;
    serial_bus_cycle_timer_monitor i_dut (.*);
    phy_link_model i_phy (.*);
    always #2 clock = !clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            err_count++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] seen, ex, input string what);
        tests_run++;
        if (seen !== ex) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, ex, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d);
        regSelect = '1;
        regWrite = wr;
        register_addr_bus = a;
        regWriteData = d;
        tick(1);
        readWord = regReadData;
        check(regReadValid, !wr, "read valid");
        regSelect = '0;
        tick(1);
    endtask
    task automatic await_tick(input int w);
        for (int k = 0; k < 400 && cycle_tick_out !== 1'h1; k++) tick(1);
        check(cycle_tick_out, 32'h1, "pulse");
        check(queueCycleMark, cycle_mark_insert_enable, "mark");
        check(queueData[11:0], '0, "mark offset");
        tick(w);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        tick(10);
        srst = '0;
        foreach (rows[i]) begin
            access(1'h1, rows[i].wa, rows[i].wd);
            access(1'h0, rows[i].ra, '0);
            check(readWord, rows[i].ex, "read");
        end
        rxQuadletValid = '1;
        rxIsCycleStart = '1;
        rxQuadlet = 32'habc_d5a5;
        tick(1);
        check({queueWrite, cycle_started_flag}, 32'h1, "rx start");
        rxQuadletValid = '0;
        tick(1);
        access(1'h0, 8'h14, '0);
        check(readWord, 32'habc_d5a5, "load");
        busSpaceRead = '1;
        busSpaceAddr = 12'h200;
        tick(1);
        check(busSpaceValid, 32'h1, "space valid");
        check(busSpaceData, 32'habc_d5a5, "space");
        busSpaceAddr = 12'h204;
        tick(1);
        check(busSpaceData, '0, "space other");
        busSpaceRead = '0;
        clearCycleStarted = '1;
        access(1'h1, 8'h14, 32'hfff3_fbf0);
        clearCycleStarted = '0;
        cycleTimerEnable = '1;
        await_tick(2);
        check(isochronousCycleTime[31:12], '0, "wrap");
        check(cycleLostFlag, '0, "armed only");
        access(1'h1, 8'h14, 32'hbf0);
        await_tick(2);
        check({cycle_started_flag, cycleLostFlag}, 32'h1, "lost");
        cycleMaster = '1;
        clearCycleLost = '1;
        access(1'h1, 8'h14, 32'hbf0);
        clearCycleLost = '0;
        check(cycleLostFlag, '0, "lost clear");
        await_tick(6);
        check(cycle_started_flag, 32'h1, "sent");
        cycle_mark_insert_enable = '0;
        cycle_source_select = '1;
        access(1'h1, 8'h14, 32'h5123);
        ext_cycle_tick_in = '0;
        tick(4);
        ext_cycle_tick_in = '1;
        await_tick(2);
        check(isochronousCycleTime[24:12], 32'h6, "ext");
        check(isochronousCycleTime[11:0], '0, "ext offset");
        srst = '1;
        tick(3);
        check({cycle_started_flag, cycleLostFlag}, '0, "reset flags");
        check(isochronousCycleTime, '0, "reset time");
        srst = '0;
        tick(2);
        check(cycle_tick_out, '0, "no pulse after reset");
        complete_run();
    end
endmodule
